// ==== inc/psam_defines.vh ====
// Constants for the power supply alert manager
`ifndef PSAM_DEFINES_VH
`define PSAM_DEFINES_VH
// ----------------------------------------------------------------------
// Register offsets (byte addresses, 32-bit words)
// ----------------------------------------------------------------------
`define PSAM_ADDR_STATUS      8'h00
`define PSAM_ADDR_MASK        8'h04
`define PSAM_ADDR_CTRL        8'h08
`define PSAM_ADDR_FAN_CMD     8'h0C
`define PSAM_ADDR_FAN_SPEED   8'h10
`define PSAM_ADDR_OT_LIMIT    8'h14
`define PSAM_ADDR_CR_CONFIG   8'h18
`define PSAM_ADDR_STATE       8'h1C
`define PSAM_ADDR_SLAVE_ADDR  8'h20
// ----------------------------------------------------------------------
// Status event bit positions
// ----------------------------------------------------------------------
`define PSAM_EV_VIN_UV        0
`define PSAM_EV_IOUT_OC_WARN  1
`define PSAM_EV_OT_WARN       2
`define PSAM_EV_POUT_OP_WARN  3
`define PSAM_EV_FAN_FAULT     4
`define PSAM_EV_OUT_FAULT     5
`define PSAM_NUM_EV           6
// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define PSAM_MASK_RESET       6'h30
`define PSAM_OT_LIMIT_RESET   16'h005A
`define PSAM_CR_STANDARD      8'h00
`define PSAM_CR_STBY1         8'h02
`define PSAM_CR_STBY2         8'h03
`define PSAM_CR_STBY3         8'h04
`define PSAM_ARA_ADDR         7'h0C
`define PSAM_SLAVE_ADDR_RESET 7'h58
// ----------------------------------------------------------------------
// Timing (times in their own units, clock 250 MHz)
// ----------------------------------------------------------------------
`define PSAM_CLK_MHZ          250
`define PSAM_T_VIN_UV_US      2000
`define PSAM_T_OC_MIN_US      10000
`define PSAM_T_OC_LATCH_S     30
`define PSAM_T_OT_HOLD_S      1
`define PSAM_CTRL_CLR_ALL     0
`define PSAM_CTRL_PWR_CYCLE   1
`endif

// ==== design/psam_alert_manager.v ====
// Alert, status, fan override and cold redundancy logic of the supply
//
// The placing of the registers and the strobed register port were decided locally.
`timescale 1ns/1ns
`include "psam_defines.vh"

module psam_alert_manager #(
   // 30 s at 250 MHz overflows 32 bits, so the long holds use 40-bit counts
   parameter [39:0]  OC_LATCH_CYC = `PSAM_T_OC_LATCH_S * `PSAM_CLK_MHZ * 40'h00000F4240,
   parameter [39:0]  OT_HOLD_CYC  = `PSAM_T_OT_HOLD_S * `PSAM_CLK_MHZ * 40'h00000F4240,
   parameter integer UV_CYC       = `PSAM_T_VIN_UV_US * `PSAM_CLK_MHZ,
   parameter integer OC_CYC       = `PSAM_T_OC_MIN_US * `PSAM_CLK_MHZ
) (
   input  wire        clk_i,
   input  wire        rst_i,
   input  wire [7:0]  addr_i,
   input  wire [31:0] wdata_i,
   input  wire        wr_i,
   input  wire        rd_i,
   output reg  [31:0] rdata_o,
   input  wire        vin_uv_i,
   input  wire        iout_oc_warn_i,
   input  wire        ot_warn_i,
   input  wire        pout_op_warn_i,
   input  wire        fan_fault_i,
   input  wire        supply_fault_i,
   input  wire        vout_low_i,
   input  wire        power_on_request_n_i,
   input  wire        cold_redundancy_enable_n_i,
   input  wire        cold_redundancy_bus_i,
   input  wire        smb_clk_i,
   input  wire [7:0]  fan_demand_i,
   input  wire [10:0] fan_tach_i,
   output reg         smb_alert_n_o,
   output reg         smb_alert_oe_o,
   output reg         cold_redundancy_bus_o,
   output reg         cold_redundancy_bus_oe_o,
   output reg         main_on_o,
   output reg         power_good_o,
   output reg  [7:0]  fan_drive_o
);

   // ---------------------------------------------------------------
   // Input synchronisers
   // ---------------------------------------------------------------
   reg [11:0] sync1_r;
   reg [11:0] sync2_r;
   reg        smb_clk_d_r;
   // Tach word runs through the same two stages as the link clock, so the
   // word and the detected edge line up and the word is settled when taken
   reg [10:0] tach1_r;
   reg [10:0] tach2_r;
   wire       vin_uv_s   = sync2_r[0];
   wire       oc_s       = sync2_r[1];
   wire       ot_s       = sync2_r[2];
   wire       op_s       = sync2_r[3];
   wire       fan_s      = sync2_r[4];
   wire       flt_s      = sync2_r[5];
   wire       vlow_s     = sync2_r[6];
   wire       power_on_request_n_n_s   = sync2_r[7];
   wire       cr_en_n_s  = sync2_r[8];
   wire       cold_redundancy_bus_s   = sync2_r[9];
   wire       smb_clk_s  = sync2_r[10];

   always @(posedge clk_i) begin
      sync1_r <= {1'b0, smb_clk_i, cold_redundancy_bus_i, cold_redundancy_enable_n_i,
                  power_on_request_n_i, vout_low_i, supply_fault_i, fan_fault_i,
                  pout_op_warn_i, ot_warn_i, iout_oc_warn_i, vin_uv_i};
      sync2_r <= sync1_r;
      smb_clk_d_r <= smb_clk_s;
      tach1_r <= fan_tach_i;
      tach2_r <= tach1_r;
   end

   // Counters stick at full scale instead of wrapping back into a window
   function [39:0] sat_inc;
      input [39:0] v;
      begin
         sat_inc = (v == 40'hFFFFFFFFFF) ? v : v + 40'h0000000001;
      end
   endfunction

   // ---------------------------------------------------------------
   // Power cycle detection
   // ---------------------------------------------------------------
   reg         power_on_request_n_n_d_r;
   wire        wr_ctrl = wr_i && (addr_i == `PSAM_ADDR_CTRL);
   // A released power-on request or software power cycle re-arms status, mask, fan command and OT limit
   wire        pwr_cycle = (power_on_request_n_n_s && !power_on_request_n_n_d_r) ||
                           (wr_ctrl && wdata_i[`PSAM_CTRL_PWR_CYCLE]);
   always @(posedge clk_i) begin
      if (rst_i)
         power_on_request_n_n_d_r <= 1'b1;
      else
         power_on_request_n_n_d_r <= power_on_request_n_n_s;
   end

   // ---------------------------------------------------------------
   // Qualification timers
   // ---------------------------------------------------------------
   reg [39:0] uv_cnt_r;
   reg [39:0] oc_cnt_r;
   reg [39:0] oc_hold_r;
   wire       uv_ev = vin_uv_s && (uv_cnt_r >= UV_CYC);
   wire       oc_q  = oc_s && (oc_cnt_r >= OC_CYC);
   // Overcurrent warning alert is dropped once held for the latch limit
   wire       oc_ev = oc_q && (oc_hold_r < OC_LATCH_CYC);

   always @(posedge clk_i) begin
      if (rst_i) begin
         uv_cnt_r  <= 40'h0000000000;
         oc_cnt_r  <= 40'h0000000000;
         oc_hold_r <= 40'h0000000000;
      end else begin
         uv_cnt_r  <= vin_uv_s ? sat_inc(uv_cnt_r) : 40'h0000000000;
         oc_cnt_r  <= oc_s ? sat_inc(oc_cnt_r) : 40'h0000000000;
         oc_hold_r <= oc_q ? sat_inc(oc_hold_r) : 40'h0000000000;
      end
   end

   // ---------------------------------------------------------------
   // Status, mask and alert
   // ---------------------------------------------------------------
   reg  [`PSAM_NUM_EV-1:0] status_r;
   reg  [`PSAM_NUM_EV-1:0] mask_r;
   wire [`PSAM_NUM_EV-1:0] cond;
   wire [`PSAM_NUM_EV-1:0] clr;
   wire                    wr_stat = wr_i && (addr_i == `PSAM_ADDR_STATUS);
   wire                    clr_all = wr_ctrl && wdata_i[`PSAM_CTRL_CLR_ALL];
   // The latched warning bit must also drop at the latch limit, or the
   // alert would outlive the cap while the overcurrent warning stays
   wire [`PSAM_NUM_EV-1:0] expire  = {{(`PSAM_NUM_EV-2){1'b0}}, oc_q && !oc_ev, 1'b0};

   // Overtemperature and overpower go straight through; sync adds 8 ns
   assign cond = {flt_s | vlow_s, fan_s, op_s, ot_s, oc_ev, uv_ev};
   assign clr  = clr_all ? {`PSAM_NUM_EV{1'b1}} :
                 (wr_stat ? wdata_i[`PSAM_NUM_EV-1:0] : {`PSAM_NUM_EV{1'b0}});

   always @(posedge clk_i) begin
      if (rst_i) begin
         status_r <= {`PSAM_NUM_EV{1'b0}};
         mask_r   <= `PSAM_MASK_RESET;
      end else begin
         // Present condition wins over clear so the bit never drops
         if (pwr_cycle)
            status_r <= cond;
         else
            status_r <= ((status_r & ~clr) | cond) & ~expire;
         if (pwr_cycle)
            mask_r <= `PSAM_MASK_RESET;
         else if (wr_i && addr_i == `PSAM_ADDR_MASK)
            mask_r <= wdata_i[`PSAM_NUM_EV-1:0];
      end
   end

   // Root bits only; summary word is not part of this path
   wire alert_req = |(status_r & ~mask_r);

   // ---------------------------------------------------------------
   // Cold redundancy and output state
   // ---------------------------------------------------------------
   reg  [7:0]  cr_cfg_r;
   reg  [39:0] ot_hold_r;
   wire        stby_role = (cr_cfg_r == `PSAM_CR_STBY1) || (cr_cfg_r == `PSAM_CR_STBY2) ||
                           (cr_cfg_r == `PSAM_CR_STBY3);
   wire        cold_stby = !power_on_request_n_n_s && cr_en_n_s && stby_role && cold_redundancy_bus_s;
   wire        main_on   = !power_on_request_n_n_s && !cold_stby;
   wire        pull_cr   = flt_s || vlow_s;

   always @(posedge clk_i) begin
      if (rst_i) begin
         cr_cfg_r  <= `PSAM_CR_STANDARD;
         ot_hold_r <= 40'h0000000000;
      end else begin
         if (!cold_redundancy_bus_s && stby_role)
            cr_cfg_r <= `PSAM_CR_STANDARD;
         else if (wr_i && addr_i == `PSAM_ADDR_CR_CONFIG)
            cr_cfg_r <= wdata_i[7:0];
         if (ot_s && !smb_alert_n_o)
            ot_hold_r <= 40'h0000000000;
         else
            ot_hold_r <= sat_inc(ot_hold_r);
      end
   end

   // Hold outputs after an overtemperature alert regardless of standby
   wire ot_keep = (ot_hold_r < OT_HOLD_CYC) && main_on_o;

   always @(posedge clk_i) begin
      if (rst_i) begin
         smb_alert_n_o            <= 1'b1;
         smb_alert_oe_o           <= 1'b0;
         cold_redundancy_bus_o    <= 1'b0;
         cold_redundancy_bus_oe_o <= 1'b0;
         main_on_o                <= 1'b0;
         power_good_o             <= 1'b0;
      end else begin
         main_on_o    <= main_on || ot_keep;
         power_good_o <= (main_on || ot_keep) && !vlow_s;
         // Open drain: pull low only, release otherwise
         smb_alert_n_o  <= !(alert_req && main_on_o);
         smb_alert_oe_o <= alert_req && main_on_o;
         cold_redundancy_bus_o    <= 1'b0;
         cold_redundancy_bus_oe_o <= pull_cr;
      end
   end

   // ---------------------------------------------------------------
   // Fan control, limit and measured speed
   // ---------------------------------------------------------------
   reg  [10:0] fan_cmd_r;
   reg  [15:0] ot_limit_r;
   reg  [10:0] fan_speed_r;
   // Duty is a percentage; anything past full scale is capped at 100
   wire [7:0]  host_duty = (fan_cmd_r > 11'h064) ? 8'h64 : fan_cmd_r[7:0];

   always @(posedge clk_i) begin
      if (rst_i || pwr_cycle) begin
         fan_cmd_r   <= 11'h000;
         ot_limit_r  <= `PSAM_OT_LIMIT_RESET;
         fan_drive_o <= 8'h00;
      end else begin
         // Mantissa only, exponent fixed at zero
         if (wr_i && addr_i == `PSAM_ADDR_FAN_CMD)
            fan_cmd_r <= wdata_i[10:0];
         if (wr_i && addr_i == `PSAM_ADDR_OT_LIMIT)
            ot_limit_r <= wdata_i[15:0];
         fan_drive_o <= (host_duty > fan_demand_i) ? host_duty : fan_demand_i;
      end
   end

   // Tach value is sampled on link clock rising edges only
   always @(posedge clk_i) begin
      if (rst_i)
         fan_speed_r <= 11'h000;
      else if (smb_clk_s && !smb_clk_d_r)
         fan_speed_r <= tach2_r;
   end

   // ---------------------------------------------------------------
   // Register read port
   // ---------------------------------------------------------------
   always @(posedge clk_i) begin
      if (rst_i)
         rdata_o <= 32'h00000000;
      else if (rd_i) begin
         case (addr_i)
            `PSAM_ADDR_STATUS:     rdata_o <= {26'h0, status_r};
            `PSAM_ADDR_MASK:       rdata_o <= {26'h0, mask_r};
            `PSAM_ADDR_FAN_CMD:    rdata_o <= {21'h0, fan_cmd_r};
            `PSAM_ADDR_FAN_SPEED:  rdata_o <= {16'h0, 5'h00, fan_speed_r};
            `PSAM_ADDR_OT_LIMIT:   rdata_o <= {16'h0, ot_limit_r};
            `PSAM_ADDR_CR_CONFIG:  rdata_o <= {24'h0, cr_cfg_r};
            `PSAM_ADDR_STATE:      rdata_o <= {28'h0, cold_stby, power_good_o,
                                               main_on_o, !smb_alert_n_o};
            // Always the normal address; never the alert response one
            `PSAM_ADDR_SLAVE_ADDR: rdata_o <= {25'h0, `PSAM_SLAVE_ADDR_RESET};
            default:               rdata_o <= 32'h00000000;
         endcase
      end else
         rdata_o <= 32'h00000000;
   end

endmodule // psam_alert_manager

// ==== tb/psam_link_model.sv ====
// Far side model of the link: clocks frames and presents fan tach data
`timescale 1ns/1ns
module psam_link_model (
   input  wire        go_i,
   input  wire [10:0] tach_i,
   output reg         smb_clk_o,
   output reg  [10:0] fan_tach_o
);
   integer k;
   initial begin
      smb_clk_o = 1'h1;
      fan_tach_o = 11'h7FF;
   end
   // Clock idles high between frames; data inverts once its hold has run out
   always @(posedge go_i) begin
      fan_tach_o = tach_i;
      for (k = 0; k < 9; k = k + 1) begin
         #32 smb_clk_o = 1'h0;
         #32 smb_clk_o = 1'h1;
      end
      #24 fan_tach_o = ~tach_i;
   end
endmodule // psam_link_model

// ==== tb/psam_checker.sv ====
// Port assertions for the alert manager
`timescale 1ns/1ns
module psam_checker #(
   parameter integer OC_CYC = 16
) (
   input wire        clk_i,
   input wire        rst_i,
   input wire [7:0]  addr_i,
   input wire [31:0] wdata_i,
   input wire        wr_i,
   input wire        rd_i,
   input wire [31:0] rdata_o,
   input wire        vin_uv_i,
   input wire        iout_oc_warn_i,
   input wire        pout_op_warn_i,
   input wire        supply_fault_i,
   input wire        smb_alert_n_o,
   input wire        smb_alert_oe_o,
   input wire        cold_redundancy_bus_o,
   input wire        cold_redundancy_bus_oe_o,
   input wire        main_on_o
);
   // Shadow ignores power-cycle restores, so it errs towards masked
   reg [5:0] msk_r;
   integer   oc_cnt_r;
   always @(posedge clk_i) begin
      if (rst_i)
         msk_r <= 6'h30;
      else if (wr_i && addr_i == 8'h04)
         msk_r <= wdata_i[5:0];
      if (rst_i || !(iout_oc_warn_i && main_on_o && !msk_r[1]))
         oc_cnt_r <= 0;
      else if (oc_cnt_r < 1000)
         oc_cnt_r <= oc_cnt_r + 1;
   end
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   property p_od;
      smb_alert_oe_o != smb_alert_n_o;
   endproperty
   a_od: assert property (p_od) else $error("alert drive inconsistent");
   property p_stby;
      !main_on_o && !$past(main_on_o) |-> !smb_alert_oe_o;
   endproperty
   a_stby: assert property (p_stby) else $error("alert while off");
   property p_ara;
      rd_i && addr_i == 8'h20 |=> rdata_o[6:0] == 7'h58;
   endproperty
   a_ara: assert property (p_ara) else $error("slave address moved");
   property p_op;
      (pout_op_warn_i && main_on_o && !msk_r[3]) [*6] |-> smb_alert_oe_o;
   endproperty
   a_op: assert property (p_op) else $error("overpower alert late");
   property p_uv;
      (vin_uv_i && main_on_o && !msk_r[0]) [*8] ##1 (vin_uv_i && main_on_o && !msk_r[0]) [*7]
         |-> smb_alert_oe_o;
   endproperty
   a_uv: assert property (p_uv) else $error("undervoltage alert late");
   property p_oc;
      oc_cnt_r == OC_CYC + 8 |-> smb_alert_oe_o;
   endproperty
   a_oc: assert property (p_oc) else $error("overcurrent alert late");
   property p_cr;
      supply_fault_i [*4] |-> cold_redundancy_bus_oe_o && !cold_redundancy_bus_o;
   endproperty
   a_cr: assert property (p_cr) else $error("shared bus not pulled");
   property p_keep;
      (pout_op_warn_i [*5] ##0 (smb_alert_oe_o && !msk_r[3]))
         |=> (smb_alert_oe_o || !main_on_o || msk_r[3]);
   endproperty
   a_keep: assert property (p_keep) else $error("alert dropped early");
endmodule // psam_checker
bind psam_alert_manager psam_checker #(.OC_CYC(OC_CYC)) psam_checker_inst (
   .clk_i(clk_i), .rst_i(rst_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
   .rd_i(rd_i), .rdata_o(rdata_o), .vin_uv_i(vin_uv_i), .iout_oc_warn_i(iout_oc_warn_i),
   .pout_op_warn_i(pout_op_warn_i), .supply_fault_i(supply_fault_i),
   .smb_alert_n_o(smb_alert_n_o), .smb_alert_oe_o(smb_alert_oe_o),
   .cold_redundancy_bus_o(cold_redundancy_bus_o),
   .cold_redundancy_bus_oe_o(cold_redundancy_bus_oe_o), .main_on_o(main_on_o));

// ==== tb/psam_alert_manager_tb.sv ====
// Self-checking bench for the alert manager
`timescale 1ns/1ns
`define CHK(a, b) begin num_checks = num_checks + 1; if ((a) !== (b)) begin \
   failures = failures + 1; $display("Error at %0t: got %h want %h", $time, a, b); end end
module psam_alert_manager_tb;
   reg         clk_i = 1'h0;
   reg         rst_i = 1'h1;
   reg  [7:0]  addr_i = 8'h00;
   reg  [31:0] wdata_i = 32'h0;
   reg         wr_i = 1'h0, rd_i = 1'h0, uv = 1'h0, oc = 1'h0, ot = 1'h0, op = 1'h0;
   reg         fan = 1'h0, sf = 1'h0, vl = 1'h0, power_on_request_n_n = 1'h1, cren_n = 1'h0;
   reg         cr_lvl = 1'h1, go = 1'h0;
   reg  [7:0]  dem = 8'h40;
   integer     failures = 0, num_checks = 0, c;
   wire [31:0] rdata;
   wire [7:0]  fan_drv;
   wire [10:0] tach;
   wire        al_n, al_oe, cr_o, cr_oe, main_on, pg, smb_clk;
   wire        cold_redundancy_bus = cr_oe ? cr_o : cr_lvl;
   always #2 clk_i = ~clk_i;
   psam_link_model psam_link_model_inst (.go_i(go), .tach_i(11'h123), .smb_clk_o(smb_clk),
      .fan_tach_o(tach));
   psam_alert_manager #(.OC_LATCH_CYC(64), .OT_HOLD_CYC(32), .UV_CYC(8), .OC_CYC(16))
   psam_alert_manager_inst (.clk_i(clk_i), .rst_i(rst_i), .addr_i(addr_i), .wdata_i(wdata_i),
      .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata), .vin_uv_i(uv), .iout_oc_warn_i(oc),
      .ot_warn_i(ot), .pout_op_warn_i(op), .fan_fault_i(fan), .supply_fault_i(sf),
      .vout_low_i(vl), .power_on_request_n_i(power_on_request_n_n), .cold_redundancy_enable_n_i(cren_n),
      .cold_redundancy_bus_i(cold_redundancy_bus), .smb_clk_i(smb_clk), .fan_demand_i(dem),
      .fan_tach_i(tach), .smb_alert_n_o(al_n), .smb_alert_oe_o(al_oe),
      .cold_redundancy_bus_o(cr_o), .cold_redundancy_bus_oe_o(cr_oe), .main_on_o(main_on),
      .power_good_o(pg), .fan_drive_o(fan_drv));
   task report_and_stop;
      if (failures == 0 && num_checks > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   task cyc(input integer n);
      repeat (n) @(posedge clk_i);
      #1;
   endtask
   task wr(input [7:0] a, input [31:0] d);
      @(posedge clk_i);
      wr_i <= 1'h1;
      addr_i <= a;
      wdata_i <= d;
      @(posedge clk_i);
      wr_i <= 1'h0;
   endtask
   task rd(input [7:0] a, input [31:0] e);
      @(posedge clk_i);
      rd_i <= 1'h1;
      addr_i <= a;
      @(posedge clk_i);
      rd_i <= 1'h0;
      #1 `CHK(rdata, e);
   endtask
   task hold(input integer n, input v);
      repeat (n) begin
         @(posedge clk_i) #1 `CHK(al_oe, v);
      end
   endtask
   // Bounded wait; a miss ends the run at once
   task waitv(input integer n, input v);
      integer i;
      for (i = 0; i < n && al_oe !== v; i = i + 1)
         @(posedge clk_i) #1;
      `CHK(al_oe, v);
      if (al_oe !== v)
         report_and_stop;
   endtask
   task t_defaults;
      rd(8'h04, 32'h30);
      rd(8'h14, 32'h5A);
      rd(8'h18, 32'h0);
      rd(8'h20, 32'h58);
      rd(8'h3C, 32'h0);
      `CHK({al_oe, al_n}, 2'h1);
      @(posedge clk_i) power_on_request_n_n <= 1'h0;
      cyc(8);
      `CHK(main_on, 1'h1);
   endtask
   task t_level;
      @(posedge clk_i) op <= 1'h1;
      waitv(30, 1'h1);
      wr(8'h00, 32'h08);
      hold(10, 1'h1);
      @(posedge clk_i) op <= 1'h0;
      hold(10, 1'h1);
      rd(8'h00, 32'h08);
      wr(8'h00, 32'h08);
      waitv(6, 1'h0);
      rd(8'h00, 32'h0);
   endtask
   task t_mask;
      wr(8'h04, 32'h38);
      rd(8'h04, 32'h38);
      @(posedge clk_i) op <= 1'h1;
      @(posedge clk_i) fan <= 1'h1;
      hold(20, 1'h0);
      wr(8'h04, 32'h30);
      waitv(6, 1'h1);
      wr(8'h04, 32'h38);
      waitv(6, 1'h0);
      @(posedge clk_i) op <= 1'h0;
      @(posedge clk_i) fan <= 1'h0;
      wr(8'h04, 32'h30);
      cyc(4);
      wr(8'h08, 32'h1);
      rd(8'h00, 32'h0);
   endtask
   task t_timing;
      @(posedge clk_i) uv <= 1'h1;
      cyc(4);
      @(posedge clk_i) uv <= 1'h0;
      hold(12, 1'h0);
      @(posedge clk_i) uv <= 1'h1;
      hold(8, 1'h0);
      waitv(20, 1'h1);
      @(posedge clk_i) uv <= 1'h0;
      @(posedge clk_i) oc <= 1'h1;
      cyc(4);
      wr(8'h08, 32'h1);
      waitv(6, 1'h0);
      hold(8, 1'h0);
      waitv(20, 1'h1);
      waitv(80, 1'h0);
      @(posedge clk_i) oc <= 1'h0;
      wr(8'h08, 32'h1);
   endtask
   task t_fan;
      wr(8'h0C, 32'h20);
      cyc(3);
      `CHK(fan_drv, 8'h40);
      wr(8'h0C, 32'h50);
      cyc(3);
      `CHK(fan_drv, 8'h50);
      @(posedge clk_i) go <= 1'h1;
      cyc(160);
      @(posedge clk_i) go <= 1'h0;
      rd(8'h10, 32'h123);
   endtask
   task t_cold;
      @(posedge clk_i) sf <= 1'h1;
      cyc(6);
      `CHK(cr_oe, 1'h1);
      @(posedge clk_i) sf <= 1'h0;
      @(posedge clk_i) vl <= 1'h1;
      cyc(6);
      `CHK(cr_oe, 1'h1);
      @(posedge clk_i) vl <= 1'h0;
      cyc(6);
      `CHK(cr_oe, 1'h0);
      @(posedge clk_i) cren_n <= 1'h1;
      for (c = 2; c < 5; c = c + 1) begin
         wr(8'h18, c);
         cyc(8);
         `CHK(main_on, 1'h0);
         @(posedge clk_i) cr_lvl <= 1'h0;
         cyc(8);
         `CHK(main_on, 1'h1);
         rd(8'h18, 32'h0);
         @(posedge clk_i) cr_lvl <= 1'h1;
      end
      @(posedge clk_i) cren_n <= 1'h0;
      wr(8'h18, 32'h2);
      cyc(8);
      `CHK(main_on, 1'h1);
      wr(8'h18, 32'h0);
   endtask
   task t_power;
      wr(8'h04, 32'h3F);
      wr(8'h14, 32'h64);
      rd(8'h14, 32'h64);
      @(posedge clk_i) power_on_request_n_n <= 1'h1;
      cyc(8);
      `CHK(main_on, 1'h0);
      @(posedge clk_i) op <= 1'h1;
      @(posedge clk_i) ot <= 1'h1;
      hold(20, 1'h0);
      @(posedge clk_i) power_on_request_n_n <= 1'h0;
      waitv(40, 1'h1);
      rd(8'h04, 32'h30);
      rd(8'h14, 32'h5A);
      cyc(32);
      `CHK(pg, 1'h1);
      @(posedge clk_i) op <= 1'h0;
      @(posedge clk_i) ot <= 1'h0;
      wr(8'h14, 32'h70);
      wr(8'h08, 32'h2);
      cyc(6);
      rd(8'h14, 32'h5A);
      `CHK(fan_drv, 8'h40);
   endtask
   initial begin
      repeat (5) @(posedge clk_i);
      rst_i <= 1'h0;
      t_defaults;
      t_level;
      t_mask;
      t_timing;
      t_fan;
      t_cold;
      t_power;
      report_and_stop;
   end
endmodule // psam_alert_manager_tb
